// *** pkg/smrtc_pkg.sv ***
package smrtc_pkg;
   // ----------------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------------
   localparam int          ADDR_W        = 15;
   localparam logic [14:0] ADDR_CTRL     = 15'h7FF8;
   localparam logic [14:0] ADDR_SEC      = 15'h7FF9;
   localparam logic [14:0] ADDR_MIN      = 15'h7FFA;
   localparam logic [14:0] ADDR_HOUR     = 15'h7FFB;
   localparam logic [14:0] ADDR_DAY      = 15'h7FFC;
   localparam logic [14:0] ADDR_DATE     = 15'h7FFD;
   localparam logic [14:0] ADDR_MONTH    = 15'h7FFE;
   localparam logic [14:0] ADDR_YEAR     = 15'h7FFF;
   localparam int          MEM_BYTES     = 32760;

   // ----------------------------------------------------------------------
   // Field positions and masks
   // ----------------------------------------------------------------------
   localparam int          CTRL_WRITE_BIT = 7;
   localparam int          CTRL_READ_BIT  = 6;
   localparam int          DAY_FLAG_BIT   = 7;
   localparam int          DAY_FT_BIT     = 6;
   localparam logic [7:0]  MASK_CENT      = 8'h3F;
   localparam logic [7:0]  MASK_SEC       = 8'h7F;
   localparam logic [7:0]  MASK_MIN       = 8'h7F;
   localparam logic [7:0]  MASK_HOUR      = 8'h3F;
   localparam logic [7:0]  MASK_DAY       = 8'h07;
   localparam logic [7:0]  MASK_DATE      = 8'h3F;
   localparam logic [7:0]  MASK_MONTH     = 8'h1F;
   localparam logic [7:0]  MASK_YEAR      = 8'hFF;

   // ----------------------------------------------------------------------
   // BCD limits and reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0]  MAX_CENT      = 8'h39;
   localparam logic [7:0]  MAX_SEC       = 8'h59;
   localparam logic [7:0]  MAX_HOUR      = 8'h23;
   localparam logic [7:0]  MAX_DAY       = 8'h07;
   localparam logic [7:0]  MAX_MONTH     = 8'h12;
   localparam logic [7:0]  MAX_YEAR      = 8'h99;
   localparam logic [7:0]  RST_ZERO      = 8'h00;
   localparam logic [7:0]  RST_ONE       = 8'h01;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int          CLK_HZ        = 20000000;
   localparam int          SECOND_S      = 1;
   localparam int          FT_HZ         = 512;
   localparam int          SEC_CYCLES    = CLK_HZ * SECOND_S;
   localparam int          FT_HALF_CYCLES = CLK_HZ / (2 * FT_HZ);
endpackage : smrtc_pkg

// *** core/smrtc_top.sv ***
`timescale 1ns/1ps
// How it works
// - Read when select and gate low, strobe high
// - Address picks memory byte or clock register
// - Clock registers sit at 7FF8 through 7FFF
// - Time kept as 24-hour BCD within ranges
// - Month lengths and leap years handled automatically
// - Host sees buffered copy; counters keep running
// - Power-fail indication blocks all host access
// - Read data follows address while selected
// - Read bit freezes host copy updates
// - Clearing read bit refreshes copy within second
// - Write when select and strobe both low
// - Write strobe turns output drivers off
// - Write bit halts; clearing loads counters
// - Frequency test toggles seconds LSB 512Hz
// - Data line 0 toggles on seconds reads while test set
// - Day register bit 7 always reads one
module smrtc_top #(
   parameter int SEC_CYCLES  = smrtc_pkg::SEC_CYCLES,
   parameter int FT_HALF     = smrtc_pkg::FT_HALF_CYCLES,
   parameter int MEM_BYTES   = smrtc_pkg::MEM_BYTES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        output_gate_n_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic [14:0] addr_lines_i,
   input  wire logic [7:0]  data_lines_i,
   input  wire logic        power_fail_i,
   output logic      [7:0]  data_lines_o,
   output logic             data_lines_oe_o
);
   // Refuse parameters that the time base or the array cannot serve
   if (SEC_CYCLES < 4 || FT_HALF < 1 || FT_HALF >= SEC_CYCLES || MEM_BYTES > smrtc_pkg::MEM_BYTES || MEM_BYTES < 1)
   begin : g_bad_params
      $error("smrtc_top: unsupported parameter values");
   end

   // ----------------------------------------------------------------------
   // BCD helpers
   // ----------------------------------------------------------------------
   // Increment BCD, wrap to lo after hi; returns wrapped flag in bit 8
   function automatic logic [8:0] smrtc_bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                                 input logic [7:0] hi);
      logic [7:0] n;
      n = 8'h00;
      if (v >= hi)
         return {1'b1, lo};
      if (v[3:0] >= 4'h9)
         n = {v[7:4] + 4'h1, 4'h0};
      else
         n = {v[7:4], v[3:0] + 4'h1};
      return {1'b0, n};
   endfunction : smrtc_bcd_inc

   // Last date of a month, leap years every fourth BCD year
   // Year 00 counts as leap; the century digits are never consulted
   function automatic logic [7:0] smrtc_month_end(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = (yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00));
      case (mon)
         8'h02:                      return leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default:                    return 8'h31;
      endcase
   endfunction : smrtc_month_end

   // ----------------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------------
   // Only the low three address bits pick a clock register; the compare
   // against the control address has already fenced off the top eight bytes.
   wire logic       sel_w     = !chip_select_n_i && !power_fail_i;
   wire logic       rd_w      = sel_w && !output_gate_n_i && write_strobe_n_i;
   wire logic       wr_w      = sel_w && !write_strobe_n_i;
   wire logic       is_clk_w  = addr_lines_i >= smrtc_pkg::ADDR_CTRL;
   wire logic [2:0] reg_idx_w = addr_lines_i[2:0];
   wire logic       mem_ok_w  = 32'(addr_lines_i) < MEM_BYTES;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   // The second is counted in clock cycles, so it is only as accurate as
   // the clock frequency that SEC_CYCLES was chosen for.
   logic [7:0] mem_r [0:MEM_BYTES-1];
   // Running counters: cent, sec, min, hour, day, date, month, year
   logic [7:0] cnt_r [0:7];
   // Host-visible copy, double buffered against the counters
   logic [7:0] vis_r [0:7];
   logic       wbit_r;
   logic       rbit_r;
   logic       ft_r;
   logic       ftq_r;
   logic       pend_r;
   logic       wr_d_r;
   logic [31:0] sec_cnt_r;
   logic [31:0] ft_cnt_r;
   logic [7:0]  dout_r;

   wire logic tick_w    = (sec_cnt_r == 32'(SEC_CYCLES - 1));
   wire logic ft_tick_w = (ft_cnt_r == 32'(FT_HALF - 1));
   wire logic wr_rise_w = wr_w && !wr_d_r;
   // A write that a power failure cuts short is dropped, not committed
   wire logic wr_end_w  = !wr_w && wr_d_r && !power_fail_i;

   // ----------------------------------------------------------------------
   // Counter next values, cascaded on each second
   // ----------------------------------------------------------------------
   // Weekday and date advance together on the hour carry; the month end
   // follows the running month and year, never the host copy.
   logic [8:0] sec_n, min_n, hour_n, date_n, mon_n, year_n, cent_n, day_n;
   always_comb
   begin
      sec_n  = smrtc_bcd_inc(cnt_r[1], 8'h00, smrtc_pkg::MAX_SEC);
      min_n  = smrtc_bcd_inc(cnt_r[2], 8'h00, smrtc_pkg::MAX_SEC);
      hour_n = smrtc_bcd_inc(cnt_r[3], 8'h00, smrtc_pkg::MAX_HOUR);
      day_n  = smrtc_bcd_inc(cnt_r[4], smrtc_pkg::RST_ONE, smrtc_pkg::MAX_DAY);
      date_n = smrtc_bcd_inc(cnt_r[5], smrtc_pkg::RST_ONE, smrtc_month_end(cnt_r[6], cnt_r[7]));
      mon_n  = smrtc_bcd_inc(cnt_r[6], smrtc_pkg::RST_ONE, smrtc_pkg::MAX_MONTH);
      year_n = smrtc_bcd_inc(cnt_r[7], 8'h00, smrtc_pkg::MAX_YEAR);
      cent_n = smrtc_bcd_inc(cnt_r[0], 8'h00, smrtc_pkg::MAX_CENT);
   end

   // Write data masked per register so don't-care bits never stick
   function automatic logic [7:0] smrtc_mask(input logic [2:0] idx);
      case (idx)
         3'd0: return smrtc_pkg::MASK_CENT;
         3'd1: return smrtc_pkg::MASK_SEC;
         3'd2: return smrtc_pkg::MASK_MIN;
         3'd3: return smrtc_pkg::MASK_HOUR;
         3'd4: return smrtc_pkg::MASK_DAY;
         3'd5: return smrtc_pkg::MASK_DATE;
         3'd6: return smrtc_pkg::MASK_MONTH;
         default: return smrtc_pkg::MASK_YEAR;
      endcase
   endfunction : smrtc_mask

   // ----------------------------------------------------------------------
   // Time base and 512 Hz test toggle
   // ----------------------------------------------------------------------
   // Both counters free-run from reset; the test toggle is not aligned to
   // the second boundary, which the host cannot observe anyway.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sec_cnt_r <= 32'h0000_0000;
         ft_cnt_r  <= 32'h0000_0000;
         ftq_r     <= 1'b0;
         wr_d_r    <= 1'b0;
      end
      else
      begin
         sec_cnt_r <= tick_w ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
         ft_cnt_r  <= ft_tick_w ? 32'h0000_0000 : ft_cnt_r + 32'h0000_0001;
         if (ft_tick_w)
            ftq_r <= !ftq_r;
         wr_d_r    <= wr_w;
      end
   end

   // ----------------------------------------------------------------------
   // Running counters; loaded from the copy when the write bit clears
   // ----------------------------------------------------------------------
   // The century comes from the clearing write itself, the rest from the copy
   // Nonvolatile operations have no path into these registers
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         for (int i = 0; i < 8; i++)
            cnt_r[i] <= (i == 4 || i == 5 || i == 6) ? smrtc_pkg::RST_ONE : smrtc_pkg::RST_ZERO;
      end
      else if (wbit_r && wr_end_w && reg_idx_w == 3'd0 && is_clk_w && !data_lines_i[7])
      begin
         for (int i = 1; i < 8; i++)
            cnt_r[i] <= vis_r[i];
         cnt_r[0] <= data_lines_i & smrtc_pkg::MASK_CENT;
      end
      else if (tick_w && !wbit_r)
      begin
         cnt_r[1] <= sec_n[7:0];
         if (sec_n[8])
         begin
            cnt_r[2] <= min_n[7:0];
            if (min_n[8])
            begin
               cnt_r[3] <= hour_n[7:0];
               if (hour_n[8])
               begin
                  cnt_r[4] <= day_n[7:0];
                  cnt_r[5] <= date_n[7:0];
                  if (date_n[8])
                  begin
                     cnt_r[6] <= mon_n[7:0];
                     if (mon_n[8])
                     begin
                        cnt_r[7] <= year_n[7:0];
                        if (year_n[8])
                           cnt_r[0] <= cent_n[7:0];
                     end
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Control bits and host-visible copy
   // ----------------------------------------------------------------------
   // The pending flag remembers a cleared read bit, so the refresh does not
   // wait for the next second as an ordinary tick would.
   // Host writes land in the first cycle after the write ends; data must
   // be held past the terminating edge, since that end cycle samples it.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wbit_r <= 1'b0;
         rbit_r <= 1'b0;
         ft_r   <= 1'b0;
         pend_r <= 1'b0;
         for (int i = 0; i < 8; i++)
            vis_r[i] <= (i == 4 || i == 5 || i == 6) ? smrtc_pkg::RST_ONE : smrtc_pkg::RST_ZERO;
      end
      else
      begin
         if (wr_end_w && is_clk_w)
         begin
            vis_r[reg_idx_w] <= data_lines_i & smrtc_mask(reg_idx_w);
            if (reg_idx_w == 3'd0)
            begin
               wbit_r <= data_lines_i[smrtc_pkg::CTRL_WRITE_BIT];
               rbit_r <= data_lines_i[smrtc_pkg::CTRL_READ_BIT];
               if (rbit_r && !data_lines_i[smrtc_pkg::CTRL_READ_BIT])
                  pend_r <= 1'b1;
            end
            if (reg_idx_w == 3'd4)
               ft_r <= data_lines_i[smrtc_pkg::DAY_FT_BIT];
         end
         else if (!wbit_r && !rbit_r && (tick_w || pend_r))
         begin
            // All registers refresh at once, from the counters
            for (int i = 0; i < 8; i++)
               vis_r[i] <= cnt_r[i];
            pend_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Memory array
   // ----------------------------------------------------------------------
   // Addresses at or above MEM_BYTES that are not clock registers read as
   // zero and swallow writes; the default map has no such hole.
   // No reset: the array content is the host's business.
   always_ff @(posedge clk_i)
   begin
      if (wr_end_w && !is_clk_w && mem_ok_w)
         mem_r[addr_lines_i] <= data_lines_i;
   end

   // ----------------------------------------------------------------------
   // Read data path; follows the address every cycle
   // ----------------------------------------------------------------------
   // The output is registered, so a new address shows one clock later;
   // that latency buys a glitch-free data bus.
   logic [7:0] clk_rd;
   always_comb
   begin
      clk_rd = vis_r[reg_idx_w];
      if (reg_idx_w == 3'd0)
         clk_rd = {wbit_r, rbit_r, vis_r[0][5:0]};
      else if (reg_idx_w == 3'd4)
         clk_rd = {1'b1, ft_r, 3'b000, vis_r[4][2:0]};
      else if (reg_idx_w == 3'd1 && ft_r)
         clk_rd = {vis_r[1][7:1], ftq_r};
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         dout_r <= 8'h00;
      else if (is_clk_w)
         dout_r <= clk_rd;
      else if (mem_ok_w)
         dout_r <= mem_r[addr_lines_i];
      else
         dout_r <= 8'h00;
   end

   // Drivers drop as soon as the strobe falls, even with the gate low
   assign data_lines_o    = dout_r;
   assign data_lines_oe_o = rd_w;
endmodule : smrtc_top

// *** verification/smrtc_assertions.sv ***
`timescale 1ns/1ps
// ----
// Port checker
// ----
module smrtc_assertions (
   input wire logic        clk_i,
   input wire logic        rst_b_i,
   input wire logic        chip_select_n_i,
   input wire logic        output_gate_n_i,
   input wire logic        write_strobe_n_i,
   input wire logic [14:0] addr_lines_i,
   input wire logic [7:0]  data_lines_i,
   input wire logic        power_fail_i,
   input wire logic [7:0]  data_lines_o,
   input wire logic        data_lines_oe_o
);
   // Valid read condition and address classes
   wire rd_c  = !chip_select_n_i && !output_gate_n_i && write_strobe_n_i && !power_fail_i;
   wire mem_a = addr_lines_i < smrtc_pkg::ADDR_CTRL;
   wire [14:0] a = addr_lines_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_oe_read_only: assert property (data_lines_oe_o |-> rd_c) else $error("oe without read");
   a_oe_on_read: assert property (rd_c |-> data_lines_oe_o) else $error("read without oe");
   a_pf_blocks: assert property (power_fail_i |-> !data_lines_oe_o) else $error("oe in power fail");
   a_strobe_off: assert property (!write_strobe_n_i |-> !data_lines_oe_o) else $error("oe in write");
   // Memory cannot change under a steady read, so the output must not move
   a_mem_steady: assert property ((rd_c && mem_a && $stable(a))[*4] |-> $stable(data_lines_o))
      else $error("memory read moved");
   a_day_flag: assert property ((rd_c && a == smrtc_pkg::ADDR_DAY)[*2] |-> data_lines_o[7])
      else $error("day flag low");
   a_sec_bcd: assert property ((rd_c && a == smrtc_pkg::ADDR_SEC)[*2]
      |-> data_lines_o[7:4] <= 4'h5 && data_lines_o[3:0] <= 4'h9) else $error("seconds bad");
   a_hour_range: assert property ((rd_c && a == smrtc_pkg::ADDR_HOUR)[*2]
      |-> data_lines_o <= 8'h23 && data_lines_o[3:0] <= 4'h9) else $error("hours bad");
   a_month_range: assert property ((rd_c && a == smrtc_pkg::ADDR_MONTH)[*2]
      |-> data_lines_o inside {[8'h01:8'h09], [8'h10:8'h12]}) else $error("month bad");
   c_write: cover property (!chip_select_n_i && !write_strobe_n_i ##1 write_strobe_n_i);
   c_sec_read: cover property ((rd_c && a == smrtc_pkg::ADDR_SEC)[*4]);
   c_pf: cover property (power_fail_i && !chip_select_n_i);
endmodule : smrtc_assertions

bind smrtc_top smrtc_assertions smrtc_assertions_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .chip_select_n_i(chip_select_n_i), .output_gate_n_i(output_gate_n_i), .write_strobe_n_i(write_strobe_n_i),
   .addr_lines_i(addr_lines_i), .data_lines_i(data_lines_i), .power_fail_i(power_fail_i),
   .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o));

// *** verification/smrtc_host_model.sv ***
`timescale 1ns/1ps
// ----
// Host bus master
// ----
module smrtc_host_model (
   input  wire logic        clk_i,
   output logic             chip_select_n_o,
   output logic             output_gate_n_o,
   output logic             write_strobe_n_o,
   output logic      [14:0] addr_lines_o,
   output logic      [7:0]  data_lines_o
);
   // Deselected and idle from time zero
   initial
   begin
      chip_select_n_o = 1'b1;
      output_gate_n_o = 1'b1;
      write_strobe_n_o = 1'b1;
      addr_lines_o = 15'h0000;
      data_lines_o = 8'hA5;
   end
   // Write: address set a cycle ahead of the strobe, which is low one cycle;
   // address and data held through the ending edge
   task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic og_n);
      @(posedge clk_i);
      #1;
      write_strobe_n_o = 1'b1;
      output_gate_n_o = og_n;
      addr_lines_o = a;
      data_lines_o = d;
      @(posedge clk_i);
      #1;
      chip_select_n_o = 1'b0;
      write_strobe_n_o = 1'b0;
      @(posedge clk_i);
      #1;
      chip_select_n_o = 1'b1;
      write_strobe_n_o = 1'b1;
      @(posedge clk_i);
      #1;
      data_lines_o = ~d; // Released bus must not keep the old byte
      output_gate_n_o = 1'b1;
   endtask : wr
   // Read: selection stays on so later reads are address driven
   task automatic rd(input logic [14:0] a);
      @(posedge clk_i);
      #1;
      chip_select_n_o = 1'b0;
      output_gate_n_o = 1'b0;
      write_strobe_n_o = 1'b1;
      addr_lines_o = a;
   endtask : rd
endmodule : smrtc_host_model

// *** verification/smrtc_top_tb.sv ***
`timescale 1ns/1ps
// ----
// Bench
// ----
module smrtc_top_tb;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        pf = 1'b0;
   logic        take = 1'b0;
   logic        cs_n, og_n, ws_n, oe;
   logic [14:0] addr;
   logic [7:0]  hd, dev_d, wire_d;
   logic [7:0]  exp_q[$], msk_q[$];
   string       nm_q[$];
   logic [15:0] lfsr = 16'h0017;
   int          failures = 0;
   int          check_count = 0;
   int          cyc = 0;
   always #25 clk_i = ~clk_i;
   // Shared data wire: device wins while it drives
   assign wire_d = oe ? dev_d : hd;
   smrtc_host_model smrtc_host_model_i (.clk_i(clk_i), .chip_select_n_o(cs_n), .output_gate_n_o(og_n),
      .write_strobe_n_o(ws_n), .addr_lines_o(addr), .data_lines_o(hd));
   smrtc_top #(.SEC_CYCLES(64), .FT_HALF(4), .MEM_BYTES(32760)) smrtc_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .chip_select_n_i(cs_n), .output_gate_n_i(og_n), .write_strobe_n_i(ws_n), .addr_lines_i(addr),
      .data_lines_i(wire_d), .power_fail_i(pf), .data_lines_o(dev_d), .data_lines_oe_o(oe));
   task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : check
   // Sixteen-bit Fibonacci LFSR, one step per call
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   // Note the expected byte, then hold the read until the result is due
   task automatic rd(input string n, input logic [14:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      nm_q.push_back(n);
      smrtc_host_model_i.rd(a);
      @(posedge clk_i);
      #1 take = 1'b1;
      @(posedge clk_i);
      #1 take = 1'b0;
   endtask : rd
   // Monitor: oldest note against the shared wire, mid-cycle when settled
   always @(negedge clk_i)
      if (take === 1'b1)
         check(nm_q.pop_front(), exp_q.pop_front(), wire_d & msk_q.pop_front());
   // Hang guard, well above the expected run
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         conclude();
      end
   end
   // Time load under the write bit; junk in don't-care bits
   task automatic set_rtc(input logic [7:0] yr, input logic [7:0] day);
      smrtc_host_model_i.wr(15'h7FF8, 8'h80, 1'b1);
      smrtc_host_model_i.wr(15'h7FF9, 8'h59, 1'b1);
      smrtc_host_model_i.wr(15'h7FFA, 8'h59, 1'b1);
      smrtc_host_model_i.wr(15'h7FFB, 8'hE3, 1'b1);
      smrtc_host_model_i.wr(15'h7FFC, day, 1'b1);
      smrtc_host_model_i.wr(15'h7FFD, 8'h28, 1'b1);
      smrtc_host_model_i.wr(15'h7FFE, 8'hE2, 1'b1);
      smrtc_host_model_i.wr(15'h7FFF, yr, 1'b1);
      smrtc_host_model_i.wr(15'h7FF8, 8'h20, 1'b1);
   endtask : set_rtc
   initial
   begin
      logic [14:0] ma[5];
      logic [7:0]  md[5];
      int          n;
      logic        p;
      repeat (6) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      // Memory bytes, random plus the top ordinary byte
      for (int k = 0; k < 5; k++)
      begin
         lfsr = lfsr_next(lfsr);
         // Clearing bit 4 keeps random addresses clear of the clock registers
         ma[k] = (k == 4) ? 15'h7FF7 : ({k[1:0], lfsr[12:0]} & 15'h7FEF);
         md[k] = lfsr[7:0] ^ lfsr[15:8];
         smrtc_host_model_i.wr(ma[k], md[k], 1'b1);
      end
      for (int k = 0; k < 5; k++)
         rd("memory", ma[k], md[k], 8'hFF);
      // Power fail: write ignored, even with the gate low
      @(posedge clk_i);
      #1 pf = 1'b1;
      smrtc_host_model_i.wr(ma[0], ~md[0], 1'b0);
      @(posedge clk_i);
      #1 pf = 1'b0;
      rd("pf memory", ma[0], md[0], 8'hFF);
      $display("memory test done");
      // Midnight roll at end of February, leap and common year
      for (int k = 0; k < 2; k++)
      begin
         set_rtc(k ? 8'h03 : 8'h04, 8'h07);
         repeat (160) @(posedge clk_i);
         smrtc_host_model_i.wr(15'h7FF8, 8'h60, 1'b1);
         rd("control", 15'h7FF8, 8'h60, 8'hFF);
         rd("seconds", 15'h7FF9, 8'h00, 8'h80);
         rd("minutes", 15'h7FFA, 8'h00, 8'hFF);
         rd("hours", 15'h7FFB, 8'h00, 8'hFF);
         rd("day", 15'h7FFC, 8'h81, 8'hFF);
         rd("date", 15'h7FFD, k ? 8'h01 : 8'h29, 8'hFF);
         rd("month", 15'h7FFE, k ? 8'h03 : 8'h02, 8'hFF);
         rd("year", 15'h7FFF, k ? 8'h03 : 8'h04, 8'hFF);
         smrtc_host_model_i.wr(15'h7FF8, 8'h20, 1'b1);
      end
      $display("calendar test done");
      // Frequency test: seconds bit 0 must keep toggling under a steady read
      set_rtc(8'h04, 8'h41);
      rd("day ft", 15'h7FFC, 8'hC1, 8'hFF);
      smrtc_host_model_i.rd(15'h7FF9);
      // First settled seconds byte shows one clock after the address
      repeat (2) @(negedge clk_i);
      p = wire_d[0];
      n = 0;
      repeat (32)
      begin
         @(negedge clk_i);
         if (wire_d[0] !== p)
            n++;
         p = wire_d[0];
      end
      // Half period of 4 cycles gives exactly 8 changes in 32 cycles
      check("ft toggles", 8'h08, 8'(n));
      set_rtc(8'h04, 8'h01);
      $display("frequency test done");
      conclude();
   end
endmodule : smrtc_top_tb
